// [jri_loader.sv]
// RAM initialization loader fed by the user JTAG macro.
// Assumes the macro's strobes and instruction follow the link clock,
// and that sys_clk reset is held for several link clock cycles.
//
// What this block does
// RULE1: Shift register moves only while the shift-DR strobe is high.
// RULE2: Address counter and block selects follow the current instruction.
// RULE3: Start opcode match starts addressing and enables selected RAM writes.
// RULE4: Update-DR strobe high marks one complete data word.
// RULE5: On update, pipeline data and address registers present the word.
// RULE6: Write clock is the inverted update strobe by default.
// RULE7: Falling-edge RAMs take the update strobe uninverted as write clock.
// RULE8: One advance pulse to the ring counter after each full block except the last.
// RULE9: Ring counter steps only under control of the address process.
// RULE10: Addresses come from an internal counter; the driver sends data only.
// RULE11: Shared mode drives every block's write enable together.
// RULE12: Opcode mode gives each block its own start opcode.
// RULE13: Address clears on start; block ends after its last address is written.
`timescale 1ns/10ps
module jri_loader
  import jri_pkg::*;
#(
  parameter int DEPTH = RAM_DEPTH,
  parameter int BLOCKS = NUM_BLOCKS,
  parameter logic [IR_W-1:0] START_CODE = START_OPCODE,
  parameter jri_sel_mode_t SEL_MODE = SEL_RING,
  parameter bit WRITE_ON_FALL = 1'b0
) (
  // System clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // Status toward the system
  output logic loadBusy,
  output logic loadDone,
  output logic wordStrobe,
  // User JTAG macro, link clock domain
  input wire logic jtagClk,
  input wire logic jtagTdi,
  input wire logic jtag_shift_dr_strobe,
  input wire logic jtag_update_dr_strobe,
  input wire logic [IR_W-1:0] user_instruction_value,
  // RAM block write side
  output jri_ram_word_t ramWord,
  output logic [BLOCKS-1:0] ramWriteEn,
  output logic ramWriteClk
);

  localparam logic [ADDR_W-1:0] ADDR_LAST = ADDR_W'(DEPTH - 1);
  localparam logic [IR_W-1:0] LAST_CODE = IR_W'(START_CODE + IR_W'(BLOCKS - 1));

  ////////////////////////////////////////////////////////////////////////////
  // Reset into the link domain

  logic linkRst;

  jri_sync #(.WIDTH(1)) u_rst_sync (
    .clk(jtagClk),
    .rst(1'b0),
    .asyncIn(reset),
    .syncOut(linkRst)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Instruction decode

  logic [IR_W-1:0] instrPrev_ff;
  logic startHit;
  logic newStart;
  logic [IR_W-1:0] blockIdx;

  always_comb begin
    blockIdx = user_instruction_value - START_CODE;
    if (SEL_MODE == SEL_OPCODE) begin
      startHit = (user_instruction_value >= START_CODE) &&
                 (user_instruction_value <= LAST_CODE); // [RULE12]
    end else begin
      startHit = (user_instruction_value == START_CODE); // [RULE3]
    end
  end

  // A fresh start each time the instruction changes to a start code
  assign newStart = startHit && (user_instruction_value != instrPrev_ff); // [RULE2]

  always_ff @(posedge jtagClk) begin
    if (linkRst) begin
      instrPrev_ff <= IR_RESET;
    end else begin
      instrPrev_ff <= user_instruction_value;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Update strobe edges

  logic updPrev_ff;
  logic updRise;
  logic updFall;

  always_ff @(posedge jtagClk) begin
    if (linkRst) begin
      updPrev_ff <= 1'b0;
    end else begin
      updPrev_ff <= jtag_update_dr_strobe;
    end
  end

  assign updRise = jtag_update_dr_strobe && !updPrev_ff; // [RULE4]
  assign updFall = !jtag_update_dr_strobe && updPrev_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Shift register

  logic [DATA_W-1:0] shift_ff;

  always_ff @(posedge jtagClk) begin
    if (linkRst) begin
      shift_ff <= DATA_RESET;
    end else if (jtag_shift_dr_strobe) begin
      shift_ff <= {jtagTdi, shift_ff[DATA_W-1:1]}; // [RULE1]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Loader state

  jri_state_t state_ff;
  logic firstWord_ff;
  logic blockEnd;
  logic lastBlock;
  logic ringLast;

  // Block ends once the write edge of the last address has passed
  assign blockEnd = (state_ff == ST_LOAD) && updFall && !firstWord_ff &&
                    (ramWord.addr == ADDR_LAST); // [RULE13]
  assign lastBlock = (SEL_MODE != SEL_RING) || ringLast;

  always_ff @(posedge jtagClk) begin
    if (linkRst) begin
      state_ff <= ST_IDLE;
    end else if (newStart) begin
      state_ff <= ST_LOAD; // [RULE3]
    end else if (!startHit) begin
      state_ff <= ST_IDLE; // [RULE2]
    end else if (blockEnd && lastBlock) begin
      state_ff <= ST_DONE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Address counter and pipeline data register

  logic [ADDR_W-1:0] addr_ff;
  logic [DATA_W-1:0] data_ff;

  always_ff @(posedge jtagClk) begin
    if (linkRst) begin
      addr_ff <= ADDR_RESET;
      firstWord_ff <= 1'b1;
    end else if (newStart) begin
      addr_ff <= ADDR_RESET; // [RULE13]
      firstWord_ff <= 1'b1;
    end else if (state_ff == ST_LOAD) begin
      if (blockEnd) begin
        firstWord_ff <= 1'b1;
      end else if (updRise) begin
        firstWord_ff <= 1'b0;
        if (firstWord_ff) begin
          addr_ff <= ADDR_RESET;
        end else begin
          addr_ff <= addr_ff + ADDR_W'(1); // [RULE5] [RULE10]
        end
      end
    end
  end

  always_ff @(posedge jtagClk) begin
    if (linkRst) begin
      data_ff <= DATA_RESET;
    end else if ((state_ff == ST_LOAD) && updRise) begin
      data_ff <= shift_ff; // [RULE5]
    end
  end

  assign ramWord = '{addr: addr_ff, data: data_ff};

  ////////////////////////////////////////////////////////////////////////////
  // Block selection

  logic [BLOCKS-1:0] ringSel;
  logic ringAdvance;

  // Only the address process may step the ring
  assign ringAdvance = blockEnd && !lastBlock; // [RULE8] [RULE9]

  jri_ring_sel #(.NUM(BLOCKS)) u_ring (
    .clk(jtagClk),
    .rst(linkRst),
    .clear(newStart),
    .advance(ringAdvance),
    .sel_ff(ringSel),
    .lastSel(ringLast)
  );

  logic loading;

  assign loading = (state_ff == ST_LOAD);

  genvar gb;
  generate
    for (gb = 0; gb < BLOCKS; gb++) begin : g_wen
      always_comb begin
        unique case (SEL_MODE)
          SEL_SHARED: ramWriteEn[gb] = loading; // [RULE11]
          SEL_OPCODE: ramWriteEn[gb] = loading && (blockIdx == IR_W'(gb)); // [RULE12]
          default: ramWriteEn[gb] = loading && ringSel[gb]; // [RULE3]
        endcase
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Write clock

  // Data settles during the strobe-high time, write edge at its end
  assign ramWriteClk = WRITE_ON_FALL ? jtag_update_dr_strobe // [RULE7]
                                     : !jtag_update_dr_strobe; // [RULE6]

  ////////////////////////////////////////////////////////////////////////////
  // Status crossing into sys_clk

  logic wordTog_ff;
  logic [2:0] sysSync;
  logic wordTogPrev_ff;

  always_ff @(posedge jtagClk) begin
    if (linkRst) begin
      wordTog_ff <= 1'b0;
    end else if (loading && updFall && !firstWord_ff) begin
      wordTog_ff <= !wordTog_ff;
    end
  end

  jri_sync #(.WIDTH(3)) u_sys_sync (
    .clk(sys_clk),
    .rst(reset),
    .asyncIn({wordTog_ff, state_ff == ST_DONE, state_ff == ST_LOAD}),
    .syncOut(sysSync)
  );

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      wordTogPrev_ff <= 1'b0;
    end else begin
      wordTogPrev_ff <= sysSync[2];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      loadBusy <= 1'b0;
      loadDone <= 1'b0;
      wordStrobe <= 1'b0;
    end else begin
      loadBusy <= sysSync[0];
      loadDone <= sysSync[1];
      wordStrobe <= sysSync[2] ^ wordTogPrev_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  property p_shift_hold;
    @(posedge jtagClk) disable iff (linkRst)
    !jtag_shift_dr_strobe |=> $stable(shift_ff);
  endproperty
  a_shift_hold: assert property (p_shift_hold) // [RULE1]
    else $error("shift register moved without shift strobe");

  property p_idle_no_write;
    @(posedge jtagClk) disable iff (linkRst)
    !startHit |=> (ramWriteEn == '0);
  endproperty
  a_idle_no_write: assert property (p_idle_no_write) // [RULE2]
    else $error("write enable active without start instruction");

  property p_start_clears;
    @(posedge jtagClk) disable iff (linkRst)
    newStart |=> (state_ff == ST_LOAD) && (ramWord.addr == ADDR_RESET) && firstWord_ff;
  endproperty
  a_start_clears: assert property (p_start_clears) // [RULE3]
    else $error("start opcode did not begin loading at address zero");

  property p_update_data;
    @(posedge jtagClk) disable iff (linkRst)
    (loading && updRise && !newStart) |=> (ramWord.data == $past(shift_ff));
  endproperty
  a_update_data: assert property (p_update_data) // [RULE5]
    else $error("pipeline data not loaded on update");

  property p_addr_step;
    @(posedge jtagClk) disable iff (linkRst)
    (loading && startHit && !newStart && updRise && !firstWord_ff)
      |=> (ramWord.addr == $past(ramWord.addr) + ADDR_W'(1));
  endproperty
  a_addr_step: assert property (p_addr_step) // [RULE10]
    else $error("address did not advance by one per word");

  property p_wclk_edge;
    @(posedge jtagClk) disable iff (linkRst)
    $rose(jtag_update_dr_strobe) |-> (ramWriteClk == WRITE_ON_FALL);
  endproperty
  a_wclk_edge: assert property (p_wclk_edge) // [RULE6] [RULE7]
    else $error("write clock polarity wrong during update");

  property p_ring_step;
    @(posedge jtagClk) disable iff (linkRst)
    (ringAdvance && !newStart) |=> (ringSel == {$past(ringSel[BLOCKS-2:0]),
                                                $past(ringSel[BLOCKS-1])});
  endproperty
  a_ring_step: assert property (p_ring_step) // [RULE8]
    else $error("ring counter did not step after block end");

  property p_ring_hold;
    @(posedge jtagClk) disable iff (linkRst)
    (!ringAdvance && !newStart) |=> $stable(ringSel);
  endproperty
  a_ring_hold: assert property (p_ring_hold) // [RULE9]
    else $error("ring counter moved outside the address process");

  property p_shared_all;
    @(posedge jtagClk) disable iff (linkRst)
    (SEL_MODE == SEL_SHARED && loading) |-> (ramWriteEn == '1);
  endproperty
  a_shared_all: assert property (p_shared_all) // [RULE11]
    else $error("shared mode left a block disabled");

  property p_opcode_onehot;
    @(posedge jtagClk) disable iff (linkRst)
    (SEL_MODE == SEL_OPCODE && loading) |-> $onehot(ramWriteEn);
  endproperty
  a_opcode_onehot: assert property (p_opcode_onehot) // [RULE12]
    else $error("opcode mode did not select exactly one block");

  property p_block_end;
    @(posedge jtagClk) disable iff (linkRst)
    blockEnd |-> (ramWord.addr == ADDR_LAST) ##1 firstWord_ff;
  endproperty
  a_block_end: assert property (p_block_end) // [RULE13]
    else $error("block ended away from the last address");

  property p_update_word;
    @(posedge jtagClk) disable iff (linkRst)
    (loading && updRise && !newStart && startHit) |=> !firstWord_ff;
  endproperty
  a_update_word: assert property (p_update_word) // [RULE4]
    else $error("update strobe not taken as a complete word");

  c_start: cover property (@(posedge jtagClk) disable iff (linkRst) newStart);
  c_block: cover property (@(posedge jtagClk) disable iff (linkRst) ringAdvance);
  c_done: cover property (@(posedge jtagClk) disable iff (linkRst)
    state_ff == ST_DONE);
  c_word: cover property (@(posedge sys_clk) disable iff (reset) wordStrobe);

endmodule

// [jri_pkg.sv]
// Shared constants and types for the JTAG driven RAM loader.
// Assumes one user JTAG macro and a bank of identical RAM blocks.
package jri_pkg;

  // Widths of the instruction, data word and RAM address
  localparam int IR_W = 8;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 9;

  // Default geometry of the RAM bank
  localparam int RAM_DEPTH = 512;
  localparam int NUM_BLOCKS = 4;

  // Default start-initialization opcode, user defined
  localparam logic [IR_W-1:0] START_OPCODE = 8'h10;

  // Reset values
  localparam logic [ADDR_W-1:0] ADDR_RESET = 9'h000;
  localparam logic [DATA_W-1:0] DATA_RESET = 8'h00;
  localparam logic [IR_W-1:0] IR_RESET = 8'h00;

  // Flip-flops in every synchroniser
  localparam int SYNC_STAGES = 2;

  // How RAM blocks are selected
  typedef enum logic [1:0] {
    SEL_RING = 2'h0,
    SEL_SHARED = 2'h1,
    SEL_OPCODE = 2'h2
  } jri_sel_mode_t;

  // Loader states, one-hot
  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_LOAD = 3'h2,
    ST_DONE = 3'h4
  } jri_state_t;

  // Address and data presented to the RAM blocks
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } jri_ram_word_t;

endpackage

// [jri_sync.sv]
// Multi-bit level synchroniser, each bit through its own flop chain.
// Assumes the bits are independent levels or slow toggles.
`timescale 1ns/10ps
module jri_sync
  import jri_pkg::*;
#(
  parameter int WIDTH = 1
) (
  // Destination clock and reset
  input wire logic clk,
  input wire logic rst,
  // Asynchronous levels in, synchronised levels out
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] stage_ff [SYNC_STAGES];

  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < SYNC_STAGES; i++) begin
        stage_ff[i] <= '0;
      end
    end else begin
      stage_ff[0] <= asyncIn;
      for (int i = 1; i < SYNC_STAGES; i++) begin
        stage_ff[i] <= stage_ff[i-1];
      end
    end
  end

  assign syncOut = stage_ff[SYNC_STAGES-1];

endmodule

// [jri_ring_sel.sv]
// One-hot ring counter that picks the RAM block being loaded.
// Assumes advance is a single-cycle pulse from the address process.
`timescale 1ns/10ps
module jri_ring_sel #(
  parameter int NUM = 4
) (
  // Link clock and reset
  input wire logic clk,
  input wire logic rst,
  // Back to the first block, and step to the next one
  input wire logic clear,
  input wire logic advance,
  // One-hot selection
  output logic [NUM-1:0] sel_ff,
  output logic lastSel
);

  localparam logic [NUM-1:0] FIRST = NUM'(1);

  always_ff @(posedge clk) begin
    if (rst || clear) begin
      sel_ff <= FIRST;
    end else if (advance) begin
      sel_ff <= {sel_ff[NUM-2:0], sel_ff[NUM-1]};
    end
  end

  assign lastSel = sel_ff[NUM-1];

endmodule

// [jri_jtag_drv.sv]
// Board-level JTAG driver model feeding the loader through the macro pins.
// Assumes the bench calls its tasks in order and gates the link clock.
`timescale 1ns/10ps
module jri_jtag_drv
  import jri_pkg::*;
(
  // Link pins toward the loader
  output logic jtagClk,
  output logic jtagTdi,
  output logic jtag_shift_dr_strobe,
  output logic jtag_update_dr_strobe,
  output logic [IR_W-1:0] user_instruction_value
);
  logic clkOn = 1'b0;

  initial begin
    jtagClk = 1'b0;
    jtagTdi = 1'b0;
    jtag_shift_dr_strobe = 1'b0;
    jtag_update_dr_strobe = 1'b0;
    user_instruction_value = IR_RESET;
  end

  // Test clock stops only when low
  always #32 if (clkOn || jtagClk) jtagClk = ~jtagClk;

  ////////////////////////////////////////////////////////////////////////////
  task automatic tick();
    @(negedge jtagClk);
  endtask

  // Instruction changes only between data scans
  task automatic setInstr(input logic [IR_W-1:0] code);
    tick();
    user_instruction_value = code;
    repeat (2) tick();
  endtask

  // Eight bits LSB first, then idle noise with shift low
  task automatic shiftWord(input logic [DATA_W-1:0] d);
    for (int i = 0; i < DATA_W; i++) begin
      tick();
      jtag_shift_dr_strobe = 1'b1;
      jtagTdi = d[i];
    end
    tick();
    jtag_shift_dr_strobe = 1'b0;
    jtagTdi = ~jtagTdi;
    repeat (2) begin
      tick();
      jtagTdi = ~jtagTdi;
    end
  endtask

  // Update-DR lasts one full test clock
  task automatic updHigh();
    tick();
    jtag_update_dr_strobe = 1'b1;
    tick();
  endtask

  task automatic updLow();
    jtag_update_dr_strobe = 1'b0;
    tick();
  endtask
endmodule

// [jri_tb.sv]
// Self-checking bench for the loader, ring selection, 4 words x 2 blocks.
// Assumes the driver model in jri_jtag_drv.sv; assertions live in the design.
`timescale 1ns/10ps
module tb;
  import jri_pkg::*;

  localparam int TB_DEPTH = 4;
  localparam int TB_BLOCKS = 2;

  logic sys_clk;
  logic reset;
  logic loadBusy;
  logic loadDone;
  logic wordStrobe;
  logic jtagClk;
  logic jtagTdi;
  logic jtag_shift_dr_strobe;
  logic jtag_update_dr_strobe;
  logic [IR_W-1:0] user_instruction_value;
  jri_ram_word_t ramWord;
  logic [TB_BLOCKS-1:0] ramWriteEn;
  logic ramWriteClk;
  logic [TB_BLOCKS-1:0] opEn;
  logic [TB_BLOCKS-1:0] shEn;
  logic opDone;
  logic shDone;
  logic opWclk;
  int failures;
  int comparisons;
  int cycles;
  int strobes;

  jri_loader #(.DEPTH(TB_DEPTH), .BLOCKS(TB_BLOCKS)) dut (
    .sys_clk(sys_clk),
    .reset(reset),
    .loadBusy(loadBusy),
    .loadDone(loadDone),
    .wordStrobe(wordStrobe),
    .jtagClk(jtagClk),
    .jtagTdi(jtagTdi),
    .jtag_shift_dr_strobe(jtag_shift_dr_strobe),
    .jtag_update_dr_strobe(jtag_update_dr_strobe),
    .user_instruction_value(user_instruction_value),
    .ramWord(ramWord),
    .ramWriteEn(ramWriteEn),
    .ramWriteClk(ramWriteClk)
  );

  // Opcode selection with falling-edge write clock
  jri_loader #(
    .DEPTH(TB_DEPTH),
    .BLOCKS(TB_BLOCKS),
    .SEL_MODE(SEL_OPCODE),
    .WRITE_ON_FALL(1'b1)
  ) dutOpc (
    .sys_clk(sys_clk),
    .reset(reset),
    .loadBusy(),
    .loadDone(opDone),
    .wordStrobe(),
    .jtagClk(jtagClk),
    .jtagTdi(jtagTdi),
    .jtag_shift_dr_strobe(jtag_shift_dr_strobe),
    .jtag_update_dr_strobe(jtag_update_dr_strobe),
    .user_instruction_value(user_instruction_value),
    .ramWord(),
    .ramWriteEn(opEn),
    .ramWriteClk(opWclk)
  );

  // One shared enable for every block
  jri_loader #(
    .DEPTH(TB_DEPTH),
    .BLOCKS(TB_BLOCKS),
    .SEL_MODE(SEL_SHARED)
  ) dutShr (
    .sys_clk(sys_clk),
    .reset(reset),
    .loadBusy(),
    .loadDone(shDone),
    .wordStrobe(),
    .jtagClk(jtagClk),
    .jtagTdi(jtagTdi),
    .jtag_shift_dr_strobe(jtag_shift_dr_strobe),
    .jtag_update_dr_strobe(jtag_update_dr_strobe),
    .user_instruction_value(user_instruction_value),
    .ramWord(),
    .ramWriteEn(shEn),
    .ramWriteClk()
  );

  jri_jtag_drv drv (
    .jtagClk(jtagClk),
    .jtagTdi(jtagTdi),
    .jtag_shift_dr_strobe(jtag_shift_dr_strobe),
    .jtag_update_dr_strobe(jtag_update_dr_strobe),
    .user_instruction_value(user_instruction_value)
  );

  initial sys_clk = 1'b0;
  always #12.5 sys_clk = ~sys_clk;

  ////////////////////////////////////////////////////////////////////////////
  // Cycle ceiling and word pulse count
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (wordStrobe === 1'b1) begin
      strobes <= strobes + 1;
    end
    if (cycles == 4000) begin
      failures = failures + 1;
      stop_test();
    end
  end

  task automatic stop_test();
    if (failures == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic check_bits(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons = comparisons + 1;
    if (got !== exp) begin
      failures = failures + 1;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic check_word(input string what, input jri_ram_word_t exp);
    comparisons = comparisons + 1;
    if (ramWord !== exp) begin
      failures = failures + 1;
      $display("MISMATCH %s expected %h seen %h", what, exp, ramWord);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    check_bits("enables", 16'h0000, 16'(ramWriteEn));
    check_bits("busy", 16'h0000, 16'(loadBusy));
    check_bits("done", 16'h0000, 16'(loadDone));
    check_word("word", '0);
  endtask

  // Non-start instruction: no enables, word ignored
  task automatic t_refuse();
    drv.setInstr(START_OPCODE + 8'h05);
    check_bits("enables", 16'h0000, 16'(ramWriteEn));
    drv.shiftWord(8'hA5);
    drv.updHigh();
    drv.updLow();
    check_word("word", '0);
  endtask

  task automatic t_load();
    logic [DATA_W-1:0] d;
    drv.setInstr(START_OPCODE);
    check_bits("enables", 16'h0001, 16'(ramWriteEn));
    check_bits("opcode enables", 16'h0001, 16'(opEn));
    check_bits("shared enables", 16'h0003, 16'(shEn));
    repeat (8) @(negedge sys_clk);
    check_bits("busy", 16'h0001, 16'(loadBusy));
    for (int b = 0; b < TB_BLOCKS; b++) begin
      for (int a = 0; a < TB_DEPTH; a++) begin
        d = DATA_W'(8'h30 + b * 16 + a);
        drv.shiftWord(d);
        drv.updHigh();
        check_bits("wclk", 16'h0000, 16'(ramWriteClk));
        check_bits("fall wclk", 16'h0001, 16'(opWclk));
        drv.updLow();
        check_bits("wclk", 16'h0001, 16'(ramWriteClk));
        check_bits("fall wclk", 16'h0000, 16'(opWclk));
        check_word("word", '{addr: ADDR_W'(a), data: d});
      end
      repeat (2) drv.tick();
      if (b == 0) begin
        check_bits("enables", 16'h0002, 16'(ramWriteEn));
        check_bits("opcode enables", 16'h0000, 16'(opEn));
      end
    end
    repeat (16) @(negedge sys_clk);
    check_bits("done", 16'h0001, 16'(loadDone));
    check_bits("opcode done", 16'h0001, 16'(opDone));
    check_bits("shared done", 16'h0001, 16'(shDone));
    check_bits("strobes", 16'(TB_DEPTH * TB_BLOCKS), 16'(strobes));
  endtask

  // Updates after the last block change nothing
  task automatic t_after_done();
    drv.shiftWord(8'h5A);
    drv.updHigh();
    drv.updLow();
    check_word("word", '{addr: ADDR_W'(TB_DEPTH - 1),
                         data: DATA_W'(8'h30 + (TB_BLOCKS - 1) * 16 + TB_DEPTH - 1)});
  endtask

  // Second opcode picks the second block only in opcode mode
  task automatic t_opcode();
    drv.setInstr(START_OPCODE + 8'h01);
    check_bits("opcode enables", 16'h0002, 16'(opEn));
    check_bits("shared enables", 16'h0000, 16'(shEn));
    check_bits("enables", 16'h0000, 16'(ramWriteEn));
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    failures = 0;
    comparisons = 0;
    cycles = 0;
    strobes = 0;
    reset = 1'b1;
    drv.clkOn = 1'b1;
    // Spans two rising test clock edges
    repeat (6) @(negedge sys_clk);
    reset = 1'b0;
    // Link side leaves reset a few test clocks later
    repeat (4) drv.tick();
    t_reset();
    t_refuse();
    t_load();
    t_after_done();
    t_opcode();
    drv.clkOn = 1'b0;
    stop_test();
  end
endmodule
